// *** gpio_pkg.sv ***
// Purpose: Constants for the three-port general-purpose I/O block.
// Assumes: Byte-wide register port, one register per printed offset.
// Notes: Byte addresses are the printed offsets.
// How it works
// - Pin-value writes load the output latch; reads return sampled pins.
// - With debug on, port A bits 0, 1, 3 ignore pin-value writes, read zero.
// - Port A bit 3 reads one with master clear, zero under debug.
// - Power-on/brown-out reset clears latches; other resets leave them.
// - Direction bit one makes the pin an input; zero drives the latch.
// - With debug on, port A direction bits 0 and 1 read one.
// - Port C bits 6 and 7 exist only in the twenty-pin variant.
// - Port A has bits 0-5, port B bits 4-7, port C bits 0-7.
// - Analog-selected pins read zero digitally; output unaffected.
// - Open-drain pins only sink or release; otherwise push-pull.
// - Weak pull-up is off whenever the pin is an output.
// - Output-latch reads return stored latch values.
package gpio_pkg;
  localparam int ADDR_W = 13;
  localparam logic [12:0] PIN_A = 13'h000C;
  localparam logic [12:0] PIN_B = 13'h000D;
  localparam logic [12:0] PIN_C = 13'h000E;
  localparam logic [12:0] DIR_A = 13'h0012;
  localparam logic [12:0] DIR_B = 13'h0013;
  localparam logic [12:0] DIR_C = 13'h0014;
  localparam logic [12:0] LAT_A = 13'h0018;
  localparam logic [12:0] LAT_B = 13'h0019;
  localparam logic [12:0] LAT_C = 13'h001A;
  localparam logic [12:0] ANS_A = 13'h1F38;
  localparam logic [12:0] WPU_A = 13'h1F39;
  localparam logic [12:0] ODC_A = 13'h1F3A;
  localparam logic [12:0] SLR_A = 13'h1F3B;
  localparam logic [12:0] INL_A = 13'h1F3C;
  localparam logic [12:0] ANS_B = 13'h1F43;
  localparam logic [12:0] WPU_B = 13'h1F44;
  localparam logic [12:0] ODC_B = 13'h1F45;
  localparam logic [12:0] SLR_B = 13'h1F46;
  localparam logic [12:0] INL_B = 13'h1F47;
  localparam logic [12:0] ANS_C = 13'h1F4E;
  localparam logic [12:0] WPU_C = 13'h1F4F;
  localparam logic [12:0] ODC_C = 13'h1F50;
  localparam logic [12:0] SLR_C = 13'h1F51;
  localparam logic [12:0] INL_C = 13'h1F52;
  // Implemented pin masks
  localparam logic [7:0] MASK_A = 8'h3F;
  localparam logic [7:0] MASK_B = 8'hF0;
  localparam logic [7:0] MASK_C20 = 8'hFF;
  localparam logic [7:0] MASK_C14 = 8'h3F;
  // Port A bit 3 is input-only: no driver, latch or direction bit
  localparam logic [7:0] MASK_A_DRV = 8'h37;
  localparam logic [7:0] MASK_A_RA3 = 8'h08;
  localparam logic [7:0] MASK_A_DBGPIN = 8'h0B;
  localparam logic [7:0] MASK_A_DBGDIR = 8'h03;
  localparam logic [7:0] MASK_A_WPU = 8'h3F;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] ANS_RST = 8'hFF;
  localparam logic [7:0] ZERO8 = 8'h00;
endpackage

// *** gpio_ports.sv ***
// Purpose: Three-port GPIO register file and pin drivers.
// Assumes: Pins arrive asynchronously; pads resolve enables externally.
// Notes: All outputs are registered; read data valid one cycle after strobe.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
module gpio_ports #(
  parameter bit TWENTY_PIN = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic powerOnReset_b,
  input wire logic debugEnable,
  input wire logic masterClearEnable,
  input wire logic [gpio_pkg::ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  input wire logic [7:0] pinInA,
  input wire logic [7:0] pinInB,
  input wire logic [7:0] pinInC,
  output logic [7:0] pinOutA,
  output logic [7:0] pinOutB,
  output logic [7:0] pinOutC,
  output logic [7:0] pinOeA,
  output logic [7:0] pinOeB,
  output logic [7:0] pinOeC,
  output logic [7:0] pullupOnA,
  output logic [7:0] pullupOnB,
  output logic [7:0] pullupOnC,
  output logic [7:0] slewLimitA,
  output logic [7:0] slewLimitB,
  output logic [7:0] slewLimitC,
  output logic [7:0] thresholdA,
  output logic [7:0] thresholdB,
  output logic [7:0] thresholdC
);
  import gpio_pkg::*;

  // Fixed by the build, so reset branches may use it as a constant
  localparam logic [7:0] maskC = TWENTY_PIN ? MASK_C20 : MASK_C14;

  // Three-stage sampler, value taken once stages two and three agree
  logic [7:0] syncA1, syncA2, syncA3, pinA;
  logic [7:0] syncB1, syncB2, syncB3, pinB;
  logic [7:0] syncC1, syncC2, syncC3, pinC;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA1 <= ZERO8; syncA2 <= ZERO8; syncA3 <= ZERO8;
      syncB1 <= ZERO8; syncB2 <= ZERO8; syncB3 <= ZERO8;
      syncC1 <= ZERO8; syncC2 <= ZERO8; syncC3 <= ZERO8;
    end else begin
      syncA1 <= pinInA; syncA2 <= syncA1; syncA3 <= syncA2;
      syncB1 <= pinInB; syncB2 <= syncB1; syncB3 <= syncB2;
      syncC1 <= pinInC; syncC2 <= syncC1; syncC3 <= syncC2;
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinA <= ZERO8;
      pinB <= ZERO8;
      pinC <= ZERO8;
    end else begin
      pinA <= (pinA & ~(syncA2 ^ syncA3)) | (syncA2 & ~(syncA2 ^ syncA3));
      pinB <= (pinB & ~(syncB2 ^ syncB3)) | (syncB2 & ~(syncB2 ^ syncB3));
      pinC <= (pinC & ~(syncC2 ^ syncC3)) | (syncC2 & ~(syncC2 ^ syncC3));
    end
  end

  logic wrPinA, wrPinB, wrPinC, wrLatA, wrLatB, wrLatC;
  assign wrPinA = regWrite && regAddr == PIN_A;
  assign wrPinB = regWrite && regAddr == PIN_B;
  assign wrPinC = regWrite && regAddr == PIN_C;
  assign wrLatA = regWrite && regAddr == LAT_A;
  assign wrLatB = regWrite && regAddr == LAT_B;
  assign wrLatC = regWrite && regAddr == LAT_C;

  // Latch mask; debug blocks pin-value writes to the debug pins
  logic [7:0] pinWrMaskA;
  assign pinWrMaskA = debugEnable ? (MASK_A_DRV & ~MASK_A_DBGPIN)
                                  : MASK_A_DRV;

  // Latches survive all resets except power-on/brown-out
  logic [7:0] out_latch_a, out_latch_b, out_latch_c;
  always_ff @(posedge core_clk or negedge powerOnReset_b) begin
    if (!powerOnReset_b) begin
      out_latch_a <= ZERO8;
      out_latch_b <= ZERO8;
      out_latch_c <= ZERO8;
    end else begin
      if (wrPinA)
        out_latch_a <= (out_latch_a & ~pinWrMaskA) | (regWdata & pinWrMaskA);
      else if (wrLatA)
        out_latch_a <= regWdata & MASK_A_DRV;
      if (wrPinB || wrLatB)
        out_latch_b <= regWdata & MASK_B;
      if (wrPinC || wrLatC)
        out_latch_c <= regWdata & maskC;
    end
  end

  logic [7:0] dirA, dirB, dirC;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      dirA <= DIR_RST;
      dirB <= DIR_RST;
      dirC <= DIR_RST;
    end else begin
      if (regWrite && regAddr == DIR_A)
        dirA <= regWdata | ~MASK_A_DRV;
      if (regWrite && regAddr == DIR_B)
        dirB <= regWdata | ~MASK_B;
      if (regWrite && regAddr == DIR_C)
        dirC <= regWdata | ~maskC;
    end
  end
  // Debug owns the low two port A drivers as inputs
  logic [7:0] dirEffA;
  assign dirEffA = debugEnable ? (dirA | MASK_A_DBGDIR) : dirA;

  logic [7:0] ansA, ansB, ansC, pullup_enable_a, pullup_enable_b, pullup_enable_c, odcA, odcB, odcC;
  logic [7:0] slrA, slrB, slrC, inlA, inlB, inlC;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ansA <= ANS_RST & MASK_A_DRV;
      ansB <= ANS_RST & MASK_B;
      ansC <= ANS_RST & maskC;
      pullup_enable_a <= ZERO8; pullup_enable_b <= ZERO8; pullup_enable_c <= ZERO8;
      odcA <= ZERO8; odcB <= ZERO8; odcC <= ZERO8;
      slrA <= ZERO8; slrB <= ZERO8; slrC <= ZERO8;
      inlA <= ZERO8; inlB <= ZERO8; inlC <= ZERO8;
    end else if (regWrite) begin
      unique case (regAddr)
        ANS_A: ansA <= regWdata & MASK_A_DRV;
        WPU_A: pullup_enable_a <= regWdata & MASK_A_WPU;
        ODC_A: odcA <= regWdata & MASK_A_DRV;
        SLR_A: slrA <= regWdata & MASK_A_DRV;
        INL_A: inlA <= regWdata & MASK_A;
        ANS_B: ansB <= regWdata & MASK_B;
        WPU_B: pullup_enable_b <= regWdata & MASK_B;
        ODC_B: odcB <= regWdata & MASK_B;
        SLR_B: slrB <= regWdata & MASK_B;
        INL_B: inlB <= regWdata & MASK_B;
        ANS_C: ansC <= regWdata & maskC;
        WPU_C: pullup_enable_c <= regWdata & maskC;
        ODC_C: odcC <= regWdata & maskC;
        SLR_C: slrC <= regWdata & maskC;
        INL_C: inlC <= regWdata & maskC;
        default: ;
      endcase
    end
  end

  // Digital reads of analog pins are zero; master clear forces bit 3 to one unless debug clears it
  logic [7:0] readPinA, readPinB, readPinC, wpuReadA;
  always_comb begin
    readPinA = pinA & ~ansA & MASK_A;
    if (masterClearEnable)
      readPinA = readPinA | MASK_A_RA3;
    if (debugEnable)
      readPinA = readPinA & ~MASK_A_DBGPIN;
    readPinB = pinB & ~ansB & MASK_B;
    readPinC = pinC & ~ansC & maskC;
    wpuReadA = masterClearEnable ? (pullup_enable_a | MASK_A_RA3) : pullup_enable_a;
  end

  logic [7:0] next_rdata;
  always_comb begin
    unique case (regAddr)
      PIN_A: next_rdata = readPinA;
      PIN_B: next_rdata = readPinB;
      PIN_C: next_rdata = readPinC;
      DIR_A: next_rdata = (dirEffA & MASK_A_DRV) | MASK_A_RA3;
      DIR_B: next_rdata = dirB & MASK_B;
      DIR_C: next_rdata = dirC & maskC;
      LAT_A: next_rdata = out_latch_a;
      LAT_B: next_rdata = out_latch_b;
      LAT_C: next_rdata = out_latch_c;
      ANS_A: next_rdata = ansA;
      WPU_A: next_rdata = wpuReadA;
      ODC_A: next_rdata = odcA;
      SLR_A: next_rdata = slrA;
      INL_A: next_rdata = inlA;
      ANS_B: next_rdata = ansB;
      WPU_B: next_rdata = pullup_enable_b;
      ODC_B: next_rdata = odcB;
      SLR_B: next_rdata = slrB;
      INL_B: next_rdata = inlB;
      ANS_C: next_rdata = ansC;
      WPU_C: next_rdata = pullup_enable_c;
      ODC_C: next_rdata = odcC;
      SLR_C: next_rdata = slrC;
      INL_C: next_rdata = inlC;
      default: next_rdata = ZERO8;
    endcase
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b)
      regRdata <= ZERO8;
    else if (regRead)
      regRdata <= next_rdata;
    else
      regRdata <= ZERO8;
  end

  // Pad drive: open drain releases on a high latch bit
  logic [7:0] drvA, drvB, drvC;
  assign drvA = ~dirEffA & MASK_A_DRV;
  assign drvB = ~dirB & MASK_B;
  assign drvC = ~dirC & maskC;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinOutA <= ZERO8; pinOutB <= ZERO8; pinOutC <= ZERO8;
      pinOeA <= ZERO8; pinOeB <= ZERO8; pinOeC <= ZERO8;
    end else begin
      pinOutA <= out_latch_a & ~odcA & drvA;
      pinOutB <= out_latch_b & ~odcB & drvB;
      pinOutC <= out_latch_c & ~odcC & drvC;
      pinOeA <= drvA & ~(odcA & out_latch_a);
      pinOeB <= drvB & ~(odcB & out_latch_b);
      pinOeC <= drvC & ~(odcC & out_latch_c);
    end
  end
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pullupOnA <= ZERO8; pullupOnB <= ZERO8; pullupOnC <= ZERO8;
      slewLimitA <= ZERO8; slewLimitB <= ZERO8; slewLimitC <= ZERO8;
      thresholdA <= ZERO8; thresholdB <= ZERO8; thresholdC <= ZERO8;
    end else begin
      pullupOnA <= wpuReadA & ~drvA;
      pullupOnB <= pullup_enable_b & ~drvB;
      pullupOnC <= pullup_enable_c & ~drvC;
      slewLimitA <= slrA; slewLimitB <= slrB; slewLimitC <= slrC;
      thresholdA <= inlA; thresholdB <= inlB; thresholdC <= inlC;
    end
  end

  property p_pin_write_latch;
    @(posedge core_clk) disable iff (!powerOnReset_b)
    wrPinC |=> out_latch_c == ($past(regWdata) & maskC);
  endproperty
  a_pin_write_latch: assert property (p_pin_write_latch)
    else $error("pin write did not load latch");
  property p_debug_read;
    @(posedge core_clk) disable iff (!rst_b)
    (regRead && regAddr == PIN_A && debugEnable)
      |=> (regRdata & MASK_A_DBGPIN) == ZERO8;
  endproperty
  a_debug_read: assert property (p_debug_read)
    else $error("debug pins read nonzero");
  property p_debug_write;
    @(posedge core_clk) disable iff (!powerOnReset_b)
    (wrPinA && debugEnable) |=>
      (out_latch_a & MASK_A_DBGPIN) == ($past(out_latch_a) & MASK_A_DBGPIN);
  endproperty
  a_debug_write: assert property (p_debug_write)
    else $error("debug pin latch changed");
  property p_mclr_read;
    @(posedge core_clk) disable iff (!rst_b)
    (regRead && regAddr == PIN_A && masterClearEnable && !debugEnable)
      |=> regRdata[3];
  endproperty
  a_mclr_read: assert property (p_mclr_read)
    else $error("bit 3 not one under master clear");
  property p_dir_drive;
    @(posedge core_clk) disable iff (!rst_b)
    dirB[4] |=> !pinOeB[4];
  endproperty
  a_dir_drive: assert property (p_dir_drive)
    else $error("input pin driven");
  property p_debug_dir;
    @(posedge core_clk) disable iff (!rst_b)
    (regRead && regAddr == DIR_A && debugEnable) |=> regRdata[1:0] == 2'h3;
  endproperty
  a_debug_dir: assert property (p_debug_dir)
    else $error("debug direction not one");
  property p_analog_zero;
    @(posedge core_clk) disable iff (!rst_b)
    (regRead && regAddr == PIN_C) |=> (regRdata & $past(ansC)) == ZERO8;
  endproperty
  a_analog_zero: assert property (p_analog_zero)
    else $error("analog pin read nonzero");
  property p_open_drain;
    @(posedge core_clk) disable iff (!rst_b)
    odcC[0] |=> !(pinOeC[0] && pinOutC[0]);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain drove high");
  property p_pullup_off;
    @(posedge core_clk) disable iff (!rst_b)
    pinOeC[2] |-> !pullupOnC[2];
  endproperty
  a_pullup_off: assert property (p_pullup_off)
    else $error("pull-up on for output");
  property p_lat_read;
    @(posedge core_clk) disable iff (!rst_b)
    (regRead && regAddr == LAT_B) |=> regRdata == $past(out_latch_b);
  endproperty
  a_lat_read: assert property (p_lat_read)
    else $error("latch read wrong");
  property p_unimpl;
    @(posedge core_clk) disable iff (!rst_b)
    (regRead && regAddr == PIN_B) |=> (regRdata & ~MASK_B) == ZERO8;
  endproperty
  a_unimpl: assert property (p_unimpl)
    else $error("unimplemented bit nonzero");
  c_write_c: cover property (@(posedge core_clk) wrPinC);
  c_debug_rd: cover property (@(posedge core_clk)
    regRead && regAddr == PIN_A && debugEnable);
  c_od_drive: cover property (@(posedge core_clk) pinOeC[0] && odcC[0]);
  property p_pin_read;
    @(posedge core_clk) disable iff (!rst_b)
    (regRead && regAddr == PIN_B)
      |=> regRdata == ($past(pinB) & ~$past(ansB) & MASK_B);
  endproperty
  a_pin_read: assert property (p_pin_read)
    else $error("pin read not from sampled pins");
  property p_debug_a3;
    @(posedge core_clk) disable iff (!rst_b)
    (regRead && regAddr == PIN_A && debugEnable && masterClearEnable)
      |=> !regRdata[3];
  endproperty
  a_debug_a3: assert property (p_debug_a3)
    else $error("bit 3 not zero under debug");
  // A write during warm reset still lands, so it is left out here
  property p_warm_keep;
    @(posedge core_clk) disable iff (!powerOnReset_b)
    (!rst_b && !regWrite) |=> out_latch_c == $past(out_latch_c);
  endproperty
  a_warm_keep: assert property (p_warm_keep)
    else $error("warm reset changed latch");
  property p_por_clear;
    @(posedge core_clk)
    !powerOnReset_b |=> (out_latch_a | out_latch_b | out_latch_c) == ZERO8;
  endproperty
  a_por_clear: assert property (p_por_clear)
    else $error("power-on reset left latch set");
  property p_drive_level;
    @(posedge core_clk) disable iff (!rst_b)
    (!dirC[3] && !odcC[3]) |=> pinOeC[3] && pinOutC[3] == $past(out_latch_c[3]);
  endproperty
  a_drive_level: assert property (p_drive_level)
    else $error("output pin not driving latch");
  property p_debug_oe;
    @(posedge core_clk) disable iff (!rst_b)
    debugEnable |=> (pinOeA & MASK_A_DBGDIR) == ZERO8;
  endproperty
  a_debug_oe: assert property (p_debug_oe)
    else $error("debug pin still driven");
  property p_lat_mask;
    @(posedge core_clk) disable iff (!powerOnReset_b)
    ((out_latch_a & ~MASK_A_DRV) | (out_latch_b & ~MASK_B) | (out_latch_c & ~maskC)) == ZERO8;
  endproperty
  a_lat_mask: assert property (p_lat_mask)
    else $error("unimplemented latch bit set");
  property p_analog_drive;
    @(posedge core_clk) disable iff (!rst_b)
    (ansC[0] && !dirC[0] && !odcC[0])
      |=> pinOeC[0] && pinOutC[0] == $past(out_latch_c[0]);
  endproperty
  a_analog_drive: assert property (p_analog_drive)
    else $error("analog select blocked output");
  property p_od_low;
    @(posedge core_clk) disable iff (!rst_b)
    (odcC[1] && !out_latch_c[1] && !dirC[1]) |=> pinOeC[1] && !pinOutC[1];
  endproperty
  a_od_low: assert property (p_od_low)
    else $error("open drain not sinking");
  property p_pullup_input;
    @(posedge core_clk) disable iff (!rst_b)
    (pullup_enable_c[5] && dirC[5]) |=> pullupOnC[5];
  endproperty
  a_pullup_input: assert property (p_pullup_input)
    else $error("pull-up off for input");
  c_warm_reset: cover property (@(posedge core_clk)
    !rst_b && powerOnReset_b);
  c_b_drive: cover property (@(posedge core_clk) pinOeB[4]);
endmodule // gpio_ports

// *** gpio_pad_model.sv ***
// Purpose: Pad and board model facing the three I/O ports.
// Assumes: Bytes packed as port C, B, A from high to low.
// Notes: A floating pad toggles each cycle so a stale level never passes.
`timescale 1ns/1ns
module gpio_pad_model (
  input wire logic core_clk,
  input wire logic [23:0] padOut,
  input wire logic [23:0] padOe,
  input wire logic [23:0] padPullup,
  input wire logic [23:0] extEn,
  input wire logic [23:0] extLevel,
  output logic [23:0] padIn
);
  logic [23:0] noise;
  initial noise = 24'hA5A5A5;
  always @(posedge core_clk) begin
    noise <= ~noise;
  end
  // Pad driver wins; then board drive, then weak pull-up, else floating
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      if (padOe[i]) begin
        padIn[i] = padOut[i];
      end else if (extEn[i]) begin
        padIn[i] = extLevel[i];
      end else if (padPullup[i]) begin
        padIn[i] = 1'b1;
      end else begin
        padIn[i] = noise[i];
      end
    end
  end
endmodule // gpio_pad_model

// *** three_port_gpio_block_tb_top.sv ***
// Purpose: Self-checking bench for the three-port I/O block.
// Assumes: Default twenty-pin build; pad model on the pin side.
// Notes: Pin reads wait past the input sampler before reading.
`timescale 1ns/1ns
module three_port_gpio_block_tb_top;
  import gpio_pkg::*;
  logic core_clk, rst_b, powerOnReset_b, debugEnable, masterClearEnable;
  logic [ADDR_W-1:0] regAddr;
  logic [7:0] regWdata;
  logic [7:0] regRdata;
  logic regWrite, regRead;
  wire [23:0] padIn, padOut, padOe, padPull;
  wire [23:0] slewOut, thrOut;
  logic [23:0] extEn, extLevel;
  int n_mismatch, total_checks;

  gpio_ports gpio_ports_i (.core_clk(core_clk), .rst_b(rst_b),
    .powerOnReset_b(powerOnReset_b), .debugEnable(debugEnable),
    .masterClearEnable(masterClearEnable), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .pinInA(padIn[7:0]), .pinInB(padIn[15:8]),
    .pinInC(padIn[23:16]), .pinOutA(padOut[7:0]), .pinOutB(padOut[15:8]),
    .pinOutC(padOut[23:16]), .pinOeA(padOe[7:0]), .pinOeB(padOe[15:8]),
    .pinOeC(padOe[23:16]), .pullupOnA(padPull[7:0]),
    .pullupOnB(padPull[15:8]), .pullupOnC(padPull[23:16]),
    .slewLimitA(slewOut[7:0]), .slewLimitB(slewOut[15:8]),
    .slewLimitC(slewOut[23:16]), .thresholdA(thrOut[7:0]),
    .thresholdB(thrOut[15:8]), .thresholdC(thrOut[23:16]));

  gpio_pad_model gpio_pad_model_i (.core_clk(core_clk), .padOut(padOut),
    .padOe(padOe), .padPullup(padPull), .extEn(extEn),
    .extLevel(extLevel), .padIn(padIn));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [7:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdchk(input string what, input logic [ADDR_W-1:0] a,
                       input logic [7:0] exp);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1;
    check(what, exp, regRdata);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic t_reset_values;
    rdchk("dir a", DIR_A, 8'h3F);
    rdchk("dir b", DIR_B, 8'hF0);
    rdchk("dir c", DIR_C, 8'hFF);
    rdchk("ansel c", ANS_C, 8'hFF);
    check("oe c", 8'h00, padOe[23:16]);
    wr(13'h0010, 8'hFF);
    rdchk("unmapped", 13'h0010, 8'h00);
    $display("test reset_values done");
  endtask

  task automatic t_pin_read;
    extEn[23:16] <= 8'hFF;
    extLevel[23:16] <= 8'hA5;
    wr(ANS_C, 8'h00);
    wr(PIN_C, 8'h3C);
    idle(6);
    rdchk("pin c", PIN_C, 8'hA5);
    rdchk("lat c", LAT_C, 8'h3C);
    wr(ANS_C, 8'h0F);
    idle(6);
    rdchk("pin c analog", PIN_C, 8'hA0);
    extEn[23:16] <= 8'h00;
    wr(DIR_C, 8'h00);
    idle(6);
    check("oe c", 8'hFF, padOe[23:16]);
    check("out c", 8'h3C, padOut[23:16]);
    rdchk("pin c driven", PIN_C, 8'h30);
    $display("test pin_read done");
  endtask

  task automatic t_masks;
    wr(LAT_B, 8'hFF);
    rdchk("lat b", LAT_B, 8'hF0);
    wr(PIN_B, 8'h5F);
    rdchk("lat b via pin", LAT_B, 8'h50);
    wr(DIR_B, 8'h00);
    idle(6);
    check("oe b", 8'hF0, padOe[15:8]);
    check("out b", 8'h50, padOut[15:8]);
    rdchk("pin b analog", PIN_B, 8'h00);
    wr(ANS_B, 8'h00);
    rdchk("pin b", PIN_B, 8'h50);
    wr(LAT_C, 8'hC3);
    rdchk("lat c", LAT_C, 8'hC3);
    $display("test masks done");
  endtask

  task automatic t_debug;
    @(posedge core_clk);
    masterClearEnable <= 1'b1;
    debugEnable <= 1'b1;
    extEn[7:0] <= 8'hFF;
    extLevel[7:0] <= 8'hFF;
    wr(LAT_A, 8'hFF);
    wr(ANS_A, 8'h00);
    wr(DIR_A, 8'h00);
    wr(PIN_A, 8'h00);
    idle(6);
    rdchk("dir a debug", DIR_A, 8'h0B);
    check("oe a debug", 8'h34, padOe[7:0]);
    rdchk("pin a debug", PIN_A, 8'h00);
    rdchk("lat a debug", LAT_A, 8'h03);
    @(posedge core_clk);
    debugEnable <= 1'b0;
    extLevel[7:0] <= 8'h00;
    idle(6);
    rdchk("pin a clear", PIN_A, 8'h0B);
    $display("test debug done");
  endtask

  // Slew and threshold registers pass straight through to their outputs; pull-up output is gated by drive
  task automatic t_config;
    wr(SLR_A, 8'hFF);
    wr(SLR_B, 8'hFF);
    wr(SLR_C, 8'hFF);
    wr(INL_A, 8'hFF);
    wr(INL_B, 8'hFF);
    wr(INL_C, 8'hFF);
    wr(ODC_A, 8'hFF);
    idle(2);
    check("slew a", 8'h37, slewOut[7:0]);
    check("slew b", 8'hF0, slewOut[15:8]);
    check("slew c", 8'hFF, slewOut[23:16]);
    check("thr a", 8'h3F, thrOut[7:0]);
    check("thr b", 8'hF0, thrOut[15:8]);
    check("thr c", 8'hFF, thrOut[23:16]);
    check("pullup a mclr", 8'h08, padPull[7:0]);
    rdchk("odc a", ODC_A, 8'h37);
    rdchk("wpu a mclr", WPU_A, 8'h08);
    $display("test config done");
  endtask

  task automatic t_drive_modes;
    wr(LAT_C, 8'hFF);
    wr(ODC_C, 8'h0F);
    idle(3);
    check("oe c od high", 8'hF0, padOe[23:16]);
    wr(LAT_C, 8'h00);
    idle(3);
    check("oe c od low", 8'hFF, padOe[23:16]);
    check("out c od low", 8'h00, padOut[23:16]);
    wr(WPU_C, 8'hFF);
    wr(DIR_C, 8'hF0);
    idle(3);
    check("pullup c", 8'hF0, padPull[23:16]);
    $display("test drive_modes done");
  endtask

  task automatic t_resets;
    wr(LAT_C, 8'h5A);
    rst_b <= 1'b0;
    idle(2);
    rst_b <= 1'b1;
    rdchk("lat c warm", LAT_C, 8'h5A);
    rdchk("dir c warm", DIR_C, 8'hFF);
    @(posedge core_clk);
    powerOnReset_b <= 1'b0;
    idle(2);
    powerOnReset_b <= 1'b1;
    rdchk("lat c cold", LAT_C, 8'h00);
    $display("test resets done");
  endtask

  initial begin
    #400000;
    n_mismatch++;
    end_sim();
  end

  initial begin
    rst_b = 1'b0;
    powerOnReset_b = 1'b0;
    debugEnable = 1'b0;
    masterClearEnable = 1'b0;
    regAddr = '0;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    extEn = 24'h000000;
    extLevel = 24'h000000;
    n_mismatch = 0;
    total_checks = 0;
    idle(5);
    rst_b <= 1'b1;
    powerOnReset_b <= 1'b1;
    t_reset_values();
    t_pin_read();
    t_masks();
    t_debug();
    t_config();
    t_drive_modes();
    t_resets();
    end_sim();
  end
endmodule // three_port_gpio_block_tb_top
